// file: pss_sequencer.sv
// Parameter set sequencer: register port, enable and restore, and advance.
// Assumes frame triggers, input lines and the frame busy flag are pins
// outside the clock domain, and software follows the setup ordering.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps

module pss_sequencer
   import pss_pkg::*;
(
   // Clock and reset.
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   // Register port.
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_write,
   input  wire logic                 reg_read,
   output logic      [31:0]          reg_rdata,
   // External pins.
   input  wire logic                 frame_trigger_pin,
   input  wire logic                 input_line1_pin,
   input  wire logic                 input_line2_pin,
   input  wire logic                 frame_busy_pin,
   // Active set and status.
   output logic      [PSS_PAR_W-1:0] active_params,
   output logic                      exposure_start,
   output logic      [PSS_IDX_W-1:0] current_set,
   output logic                      sequencer_running
);

   // ==========================================================================
   // Pin synchronisation.
   logic [3:0] pin_level;   // Synchronised pin levels.
   logic [3:0] pin_rise;    // One-cycle rises of the pins.
   logic       trig_rise;   // Frame start trigger arrived.
   logic       line1;       // Input line 1 level.
   logic       line2;       // Input line 2 level.
   logic       frame_busy;  // Exposure, readout or transmission running.

   pss_pin_sync u_sync (
      .clock     (clock),
      .reset_n   (reset_n),
      .pin_raw   ({frame_busy_pin, input_line2_pin, input_line1_pin,
                   frame_trigger_pin}),
      .pin_level (pin_level),
      .pin_rise  (pin_rise)
   );

   assign trig_rise  = pin_rise[0];
   assign line1      = pin_level[1];
   assign line2      = pin_level[2];
   assign frame_busy = pin_level[3];

   // ==========================================================================
   // Register state.
   logic                 seq_on_r;      // Sequencer on, written by software.
   logic                 policy_r;      // Zero automatic, one controlled.
   pss_src_e             src_r;         // Control source for controlled policy.
   logic [PSS_CNT_W-1:0] set_count_r;   // Sets taking part in a cycle.
   logic [PSS_IDX_W-1:0] set_select_r;  // Target of save and load.
   logic [PSS_REP_W-1:0] repeat_r;      // Repeat count stored with a save.
   logic [PSS_PAR_W-1:0] active_r;      // Active set values.
   logic [PSS_PAR_W-1:0] backup_r;      // Active values from before enabling.
   pss_state_e           state_r;       // Sequencer state.
   pss_state_e           state_nxt;     // Next sequencer state.
   logic [PSS_IDX_W-1:0] cur_r;         // Set in use.
   logic [PSS_REP_W-1:0] cur_rep_r;     // Repeat count of the set in use.
   logic [PSS_REP_W-1:0] use_cnt_r;     // Uses of the current set so far.
   logic                 expo_r;        // Exposure start pulse.
   logic [31:0]          rdata_r;       // Read data for the cycle after a read.
   logic                 running_r;     // Running or draining, for the output.

   // ==========================================================================
   // Decoded strobes.
   logic wr_ctrl;    // Write to control.
   logic wr_cmd;     // Write to command.
   logic save_cmd;   // Save active values into selected set.
   logic sw_adv;     // Software advance command.
   logic load_cmd;   // Load selected set while idle.

   assign wr_ctrl  = reg_write && (reg_addr == PSS_ADDR_CTRL);
   assign wr_cmd   = reg_write && (reg_addr == PSS_ADDR_CMD);
   assign save_cmd = wr_cmd && reg_wdata[PSS_CMD_SAVE_BIT];
   assign sw_adv   = wr_cmd && reg_wdata[PSS_CMD_ADV_BIT];
   assign load_cmd = wr_cmd && reg_wdata[PSS_CMD_LOAD_BIT] && (state_r == PSS_ST_IDLE);

   // ==========================================================================
   // Advance decision.
   logic                 run;          // Cycling through sets.
   logic                 start;        // Enable seen while idle.
   logic                 ctl_adv;      // Controlled policy advance.
   logic                 auto_adv;     // Automatic policy advance.
   logic                 auto_use;     // Automatic policy reuses current set.
   logic                 advance;      // Move to the next set now.
   logic [PSS_IDX_W-1:0] next_idx;     // Next higher index, wrapped.
   logic [PSS_IDX_W-1:0] rd_idx;       // Store read index.
   logic [PSS_PAR_W-1:0] rd_param;     // Store read values.
   logic [PSS_REP_W-1:0] rd_repeat;    // Store read repeat count.
   logic [PSS_CNT_W-1:0] cur_plus;     // Current index plus one.

   // Triggers only steer the sequence while running and still enabled, so a
   // trigger that lands during the drain of a disable cannot move the set.
   always_comb begin
      run      = (state_r == PSS_ST_RUN) && seq_on_r;
      start    = (state_r == PSS_ST_IDLE) && seq_on_r;
      cur_plus = {1'b0, cur_r} + 7'h01;
      // Wrap at the top of the cycle; the compare also covers a count
      // lowered below the current index.
      next_idx = (cur_plus >= set_count_r) ? '0 : cur_plus[PSS_IDX_W-1:0];   // RULE15 RULE9
      ctl_adv  = 1'b0;
      if (run && policy_r) begin   // RULE8
         case (src_r)
            PSS_SRC_EVERY: ctl_adv = trig_rise;            // RULE10 RULE14
            PSS_SRC_LINE1: ctl_adv = trig_rise && line1;   // RULE11
            PSS_SRC_LINE2: ctl_adv = trig_rise && line2;   // RULE11
            PSS_SRC_OFF:   ctl_adv = sw_adv;               // RULE12
            default:       ctl_adv = 1'b0;
         endcase
      end
      // Automatic policy advances once the current set has been used its
      // repeat count of times; the very first trigger finds zero uses.
      auto_adv = run && !policy_r && trig_rise && (use_cnt_r >= cur_rep_r);   // RULE17
      auto_use = run && !policy_r && trig_rise && (use_cnt_r < cur_rep_r);    // RULE18
      advance  = ctl_adv || auto_adv;
      if (start) begin
         rd_idx = '0;   // RULE13
      end else if (advance) begin
         rd_idx = next_idx;
      end else if (load_cmd) begin
         rd_idx = set_select_r;
      end else begin
         rd_idx = cur_r;
      end
   end

   // ==========================================================================
   // Stored sets.
   pss_set_store u_store (
      .clock     (clock),
      .reset_n   (reset_n),
      .wr_en     (save_cmd),
      .wr_idx    (set_select_r),   // RULE2
      .wr_param  (active_r),
      .wr_repeat (repeat_r),
      .rd_idx    (rd_idx),
      .rd_param  (rd_param),
      .rd_repeat (rd_repeat)
   );

   // ==========================================================================
   // Configuration registers.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         seq_on_r     <= 1'b0;
         policy_r     <= 1'b0;
         src_r        <= PSS_SRC_EVERY;
         set_count_r  <= PSS_COUNT_RST;
         set_select_r <= '0;
         repeat_r     <= PSS_REPEAT_RST;
      end else if (reg_write) begin
         if (wr_ctrl) begin
            seq_on_r <= reg_wdata[PSS_CTRL_ON_BIT];
            policy_r <= reg_wdata[PSS_CTRL_POL_BIT];
            src_r    <= pss_src_e'(reg_wdata[PSS_CTRL_SRC_LSB +: 2]);
         end
         // Out of range counts are clamped so the index math stays valid.
         if (reg_addr == PSS_ADDR_COUNT) begin
            if (reg_wdata > 32'(PSS_COUNT_MAX)) begin
               set_count_r <= PSS_COUNT_MAX;   // RULE1
            end else if (reg_wdata == 32'h0000_0000) begin
               set_count_r <= PSS_COUNT_RST;
            end else begin
               set_count_r <= reg_wdata[PSS_CNT_W-1:0];   // RULE1
            end
         end
         if (reg_addr == PSS_ADDR_SELECT) begin
            set_select_r <= reg_wdata[PSS_IDX_W-1:0];   // RULE2
         end
         if (reg_addr == PSS_ADDR_REPEAT) begin
            if (reg_wdata > 32'(PSS_REPEAT_MAX)) begin
               repeat_r <= PSS_REPEAT_MAX;   // RULE3
            end else if (reg_wdata == 32'h0000_0000) begin
               repeat_r <= PSS_REPEAT_RST;   // RULE3
            end else begin
               repeat_r <= reg_wdata[PSS_REP_W-1:0];
            end
         end
      end
   end

   // ==========================================================================
   // Sequencer state.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PSS_ST_IDLE: begin
            if (seq_on_r) begin
               state_nxt = PSS_ST_RUN;
            end
         end
         PSS_ST_RUN: begin
            // A frame in flight is finished before the cycle ends.
            if (!seq_on_r) begin
               state_nxt = frame_busy ? PSS_ST_DRAIN : PSS_ST_IDLE;   // RULE19
            end
         end
         PSS_ST_DRAIN: begin
            if (!frame_busy) begin
               state_nxt = PSS_ST_IDLE;   // RULE19
            end
         end
         default: state_nxt = PSS_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_r <= PSS_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================================
   // Active values, backup and current set.
   // The load happens on the edge that detects the trigger, the same edge that
   // raises the exposure start pulse, so the exposure always sees the new set.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         active_r  <= PSS_PARAM_DEF;
         backup_r  <= PSS_PARAM_DEF;
         cur_r     <= '0;
         cur_rep_r <= PSS_REPEAT_RST;
      end else if (start) begin
         backup_r  <= active_r;    // RULE16
         active_r  <= rd_param;    // RULE13
         cur_r     <= '0;          // RULE13
         cur_rep_r <= rd_repeat;
      end else if (advance) begin
         active_r  <= rd_param;    // RULE21
         cur_r     <= next_idx;    // RULE15
         cur_rep_r <= rd_repeat;
      end else if ((state_r != PSS_ST_IDLE) && (state_nxt == PSS_ST_IDLE)) begin
         active_r <= backup_r;     // RULE16
      end else if (load_cmd) begin
         active_r <= rd_param;
      end else if (reg_write && (reg_addr == PSS_ADDR_ACTIVE) &&
                   (state_r == PSS_ST_IDLE)) begin
         active_r <= reg_wdata;
      end
   end

   // Use counter: cleared on enable, restarted on every move to a new set.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         use_cnt_r <= '0;
      end else if (start || ctl_adv) begin
         use_cnt_r <= '0;                 // RULE20
      end else if (auto_adv) begin
         use_cnt_r <= PSS_REPEAT_RST;     // RULE20
      end else if (auto_use) begin
         use_cnt_r <= use_cnt_r + 9'h001; // RULE17
      end
   end

   // Exposure start follows the trigger by one cycle, on the same edge as any triggered load.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         expo_r <= 1'b0;
      end else begin
         expo_r <= trig_rise;   // RULE21
      end
   end

   // Running flag, registered so the status output comes from a flip-flop.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         running_r <= 1'b0;
      end else begin
         running_r <= (state_nxt != PSS_ST_IDLE);   // RULE19
      end
   end

   // ==========================================================================
   // Read data, valid only in the cycle after the read strobe.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (reg_read) begin
         case (reg_addr)
            PSS_ADDR_CTRL:   rdata_r <= {28'h000_0000, src_r, policy_r, seq_on_r};
            PSS_ADDR_COUNT:  rdata_r <= 32'(set_count_r);
            PSS_ADDR_SELECT: rdata_r <= 32'(set_select_r);
            PSS_ADDR_REPEAT: rdata_r <= 32'(repeat_r);
            PSS_ADDR_ACTIVE: rdata_r <= active_r;
            PSS_ADDR_STATUS: rdata_r <= (32'(use_cnt_r) << PSS_STAT_USE_LSB) |
                                        (32'(state_r) << PSS_STAT_ST_LSB) |
                                        32'(cur_r);
            default:         rdata_r <= 32'h0000_0000;
         endcase
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   assign reg_rdata         = rdata_r;
   assign active_params     = active_r;
   assign exposure_start    = expo_r;
   assign current_set       = cur_r;
   assign sequencer_running = running_r;

   // ==========================================================================
   // Checks.
   count_range_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE1
      (set_count_r <= PSS_COUNT_MAX) && (set_count_r != '0))
      else $error("set count out of range");

   enable_load_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE13
      start |=> (cur_r == '0) && (active_r == $past(rd_param)))
      else $error("enable did not load set zero");

   wrap_zero_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE15
      (advance && !start && (cur_plus >= set_count_r)) |=> (cur_r == '0))
      else $error("advance did not wrap to zero");

   every_trig_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE10
      (run && policy_r && (src_r == PSS_SRC_EVERY) && trig_rise)
      |=> (cur_r == $past(next_idx)) && (use_cnt_r == '0))
      else $error("trigger did not advance the set");

   soft_only_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE12
      (run && policy_r && (src_r == PSS_SRC_OFF) && !sw_adv) |=> $stable(cur_r))
      else $error("set moved without software command");

   auto_repeat_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE17
      auto_use |=> $stable(cur_r) && (use_cnt_r == $past(use_cnt_r) + 9'h001))
      else $error("repeat use miscounted");

   auto_first_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE18
      (run && !policy_r && trig_rise && (use_cnt_r == '0)) |=> (cur_r == '0))
      else $error("first automatic trigger left set zero");

   restore_on_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE16
      ((state_r != PSS_ST_IDLE) && (state_nxt == PSS_ST_IDLE))
      |=> (active_r == $past(backup_r)) && (state_r == PSS_ST_IDLE))
      else $error("active values not restored");

   drain_wait_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE19
      ((state_r == PSS_ST_RUN) && !seq_on_r && frame_busy) ##1 frame_busy
      |-> (state_r == PSS_ST_DRAIN) && !$changed(cur_r))
      else $error("disable did not wait for frame");

   load_first_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE21
      (trig_rise && advance) |=> expo_r && (active_r == $past(rd_param)))
      else $error("exposure started before set load");

endmodule : pss_sequencer

// file: pss_pkg.sv
// Constants, types and field layout shared by the parameter set sequencer.
// Assumes a single 125 MHz clock domain and a plain strobe register port.
//
// Overview of operation
// [RULE1] Set count accepted up to 64.
// [RULE2] Select index picks any set 0 to 63.
// [RULE3] Each set holds repeat count 1 to 256.
// [RULE4] Save command copies active values into selected set.
// [RULE5] Never saved sets supply default values.
// [RULE6] Software disables sequencer before changing setup.
// [RULE7] Software fills sets contiguously from zero.
// [RULE8] Advance follows automatic or controlled policy.
// [RULE9] Controlled advance goes up; four sources.
// [RULE10] Every trigger source advances on each trigger.
// [RULE11] Line source advances when selected line high.
// [RULE12] Disabled source advances only on software command.
// [RULE13] Enabling loads set zero into active values.
// [RULE14] Controlled every trigger: first frame uses set 1.
// [RULE15] After highest set, advance wraps to zero.
// [RULE16] Disabling restores the pre-enable active values.
// [RULE17] Automatic policy uses each set repeat times.
// [RULE18] Automatic policy: first trigger uses set zero.
// [RULE19] Disable during frame waits for frame end.
// [RULE20] Use counter clears on set change or enable; an automatic advance loads it with one instead.
// [RULE21] Set load completes before triggered exposure starts.

package pss_pkg;

   // ==========================================================================
   // Sizes.
   localparam int PSS_SETS  = 64;   // Number of stored parameter sets.
   localparam int PSS_IDX_W = 6;    // Width of a set index.
   localparam int PSS_CNT_W = 7;    // Width of the set count.
   localparam int PSS_REP_W = 9;    // Width of a repeat count.
   localparam int PSS_PAR_W = 32;   // Width of the sequenced parameter word.

   // ==========================================================================
   // Register offsets.
   localparam logic [7:0] PSS_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] PSS_ADDR_COUNT  = 8'h04;
   localparam logic [7:0] PSS_ADDR_SELECT = 8'h08;
   localparam logic [7:0] PSS_ADDR_REPEAT = 8'h0C;
   localparam logic [7:0] PSS_ADDR_CMD    = 8'h10;
   localparam logic [7:0] PSS_ADDR_ACTIVE = 8'h14;
   localparam logic [7:0] PSS_ADDR_STATUS = 8'h18;

   // ==========================================================================
   // Field positions.
   localparam int PSS_CTRL_ON_BIT  = 0;   // Sequencer on.
   localparam int PSS_CTRL_POL_BIT = 1;   // Advance policy, one is controlled.
   localparam int PSS_CTRL_SRC_LSB = 2;   // Two bit control source.
   localparam int PSS_CMD_SAVE_BIT = 0;   // Save active values to selected set.
   localparam int PSS_CMD_ADV_BIT  = 1;   // Software advance command.
   localparam int PSS_CMD_LOAD_BIT = 2;   // Load selected set into active values.
   localparam int PSS_STAT_ST_LSB  = 8;   // State field in status.
   localparam int PSS_STAT_USE_LSB = 16;  // Use counter field in status.

   // ==========================================================================
   // Reset values and limits.
   localparam logic [PSS_CNT_W-1:0] PSS_COUNT_RST  = 7'h01;
   localparam logic [PSS_CNT_W-1:0] PSS_COUNT_MAX  = 7'h40;
   localparam logic [PSS_REP_W-1:0] PSS_REPEAT_RST = 9'h001;
   localparam logic [PSS_REP_W-1:0] PSS_REPEAT_MAX = 9'h100;
   localparam logic [PSS_PAR_W-1:0] PSS_PARAM_DEF  = 32'h0000_0000;

   // ==========================================================================
   // Enumerations.
   typedef enum logic [1:0] {
      PSS_SRC_EVERY = 2'b00,
      PSS_SRC_LINE1 = 2'b01,
      PSS_SRC_LINE2 = 2'b10,
      PSS_SRC_OFF   = 2'b11
   } pss_src_e;

   typedef enum logic [1:0] {
      PSS_ST_IDLE  = 2'b00,
      PSS_ST_RUN   = 2'b01,
      PSS_ST_DRAIN = 2'b10
   } pss_state_e;

endpackage : pss_pkg

// file: pss_pin_sync.sv
// Two-stage synchronisers and rise detectors for the four external pins.
// Assumes the pins are asynchronous to clock and held for several cycles.
`timescale 1ns/10ps

module pss_pin_sync
   import pss_pkg::*;
(
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Raw pins.
   input  wire logic [3:0] pin_raw,
   // Synchronised levels and one-cycle rises.
   output logic      [3:0] pin_level,
   output logic      [3:0] pin_rise
);

   // ==========================================================================
   // Per pin chain.
   logic [3:0] meta_r;   // First stage, read only by the second stage.
   logic [3:0] sync_r;   // Second stage, safe to use.
   logic [3:0] last_r;   // Previous safe value for edge detection.

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pin
         // The edge detector looks only at the second and third stages.
         always_ff @(posedge clock) begin
            if (!reset_n) begin
               meta_r[g] <= 1'b0;
               sync_r[g] <= 1'b0;
               last_r[g] <= 1'b0;
            end else begin
               meta_r[g] <= pin_raw[g];
               sync_r[g] <= meta_r[g];
               last_r[g] <= sync_r[g];
            end
         end
         assign pin_level[g] = sync_r[g];
         assign pin_rise[g]  = sync_r[g] & ~last_r[g];
      end
   endgenerate

endmodule : pss_pin_sync

// file: pss_set_store.sv
// Flip-flop storage for the stored parameter sets and their repeat counts.
// Assumes one write and one combinational read per cycle from the sequencer.
`timescale 1ns/10ps

module pss_set_store
   import pss_pkg::*;
(
   // Clock and reset.
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   // Write port.
   input  wire logic                 wr_en,
   input  wire logic [PSS_IDX_W-1:0] wr_idx,
   input  wire logic [PSS_PAR_W-1:0] wr_param,
   input  wire logic [PSS_REP_W-1:0] wr_repeat,
   // Read port.
   input  wire logic [PSS_IDX_W-1:0] rd_idx,
   output logic      [PSS_PAR_W-1:0] rd_param,
   output logic      [PSS_REP_W-1:0] rd_repeat
);

   // ==========================================================================
   // Storage.
   logic [PSS_SETS-1:0]  saved_r;             // Set has been written once.
   logic [PSS_PAR_W-1:0] param_r [PSS_SETS];  // Stored parameter words.
   logic [PSS_REP_W-1:0] rep_r   [PSS_SETS];  // Stored repeat counts.

   genvar g;
   generate
      for (g = 0; g < PSS_SETS; g++) begin : g_set
         // Each entry is replaced whole by a save aimed at it.
         always_ff @(posedge clock) begin
            if (!reset_n) begin
               saved_r[g] <= 1'b0;
               param_r[g] <= PSS_PARAM_DEF;
               rep_r[g]   <= PSS_REPEAT_RST;
            end else if (wr_en && (wr_idx == PSS_IDX_W'(g))) begin
               saved_r[g] <= 1'b1;        // RULE4
               param_r[g] <= wr_param;    // RULE4
               rep_r[g]   <= wr_repeat;   // RULE3
            end
         end
      end
   endgenerate

   // ==========================================================================
   // A set that was never saved reads back as defaults.
   always_comb begin
      rd_param  = saved_r[rd_idx] ? param_r[rd_idx] : PSS_PARAM_DEF;   // RULE5
      rd_repeat = saved_r[rd_idx] ? rep_r[rd_idx] : PSS_REPEAT_RST;    // RULE5
   end

endmodule : pss_set_store

// file: pss_far_end.sv
// Far-side model: frame trigger source, input lines and frame busy flag.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/10ps

module pss_far_end (
   // Clock.
   input  wire logic clock,
   // Pins towards the sequencer.
   output logic      frame_trigger_pin,
   output logic      input_line1_pin,
   output logic      input_line2_pin,
   output logic      frame_busy_pin
);
   // ==========================================================================
   // Pins idle low until the bench asks for traffic.
   initial begin
      frame_trigger_pin = 1'b0;
      input_line1_pin   = 1'b0;
      input_line2_pin   = 1'b0;
      frame_busy_pin    = 1'b0;
   end

   // One frame: the pulse stays high and low for four cycles each, because the
   // synchroniser needs two edges to see a rise and a gap before the next.
   task automatic fire();
      frame_trigger_pin <= 1'b1;
      frame_busy_pin    <= 1'b1;
      repeat (4) @(posedge clock);
      frame_trigger_pin <= 1'b0;
      frame_busy_pin    <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : fire

   // Levels that steer a line-controlled advance; set no later than the trigger.
   task automatic lines(input logic a, input logic b);
      input_line1_pin <= a;
      input_line2_pin <= b;
   endtask : lines

   // Holds the frame busy flag, to disable the sequencer during a frame.
   task automatic busy(input logic b);
      frame_busy_pin <= b;
   endtask : busy
endmodule : pss_far_end

// file: test_parameter_set_sequencer.sv
// Bench for the parameter set sequencer: setup, auto and controlled runs.
// Assumes the far-end model drives the pins; the design asserts itself.
`timescale 1ns/10ps

module test_parameter_set_sequencer
   import pss_pkg::*;
;
   // ==========================================================================
   // Connections, all inputs given a value at time zero.
   logic                 clock     = 1'b0;
   logic                 reset_n   = 1'b0;
   logic [7:0]           reg_addr  = 8'h00;
   logic [31:0]          reg_wdata = 32'h0000_0000;
   logic                 reg_write = 1'b0;
   logic                 reg_read  = 1'b0;
   logic [31:0]          reg_rdata;
   logic [PSS_PAR_W-1:0] active_params;
   logic [PSS_IDX_W-1:0] current_set;
   logic                 sequencer_running;
   logic                 frame_trigger_pin, input_line1_pin, input_line2_pin, frame_busy_pin;
   logic                 exposure_start;
   int                   expo_cnt = 0;   // Exposure start pulses seen.
   int                   error_cnt = 0;
   int                   num_checks = 0;
   int                   auto_set[5] = '{0, 0, 1, 1, 0};   // Repeats are 1 and 2.

   always #4 clock = ~clock;
   always @(posedge clock) if (exposure_start) expo_cnt++;

   pss_sequencer uut (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .frame_trigger_pin, .input_line1_pin, .input_line2_pin,
      .frame_busy_pin, .active_params, .exposure_start, .current_set, .sequencer_running);
   pss_far_end far (.clock, .frame_trigger_pin, .input_line1_pin, .input_line2_pin,
      .frame_busy_pin);

   // ==========================================================================
   // Compare, bus cycles and verdict.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      repeat (2) @(posedge clock);   // Lets a control change take hold.
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask : rd
   // Set s in use carries the value that was saved into it.
   task automatic see(input int s);
      #1;
      chk(32'(current_set), 32'(s));
      chk(active_params, 32'h0000_0011 * 32'(s + 1));
   endtask : see
   task automatic test_done();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // ==========================================================================
   // Watchdog: a hang counts as a mismatch.
   initial begin
      #200000;
      error_cnt++;
      test_done();
   end

   initial begin
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      wr(PSS_ADDR_COUNT, 32'h0000_0064);
      rd(PSS_ADDR_COUNT, 32'h0000_0040);
      wr(PSS_ADDR_COUNT, 32'h0000_0002);
      for (int i = 0; i < 2; i++) begin
         wr(PSS_ADDR_SELECT, 32'(i));
         wr(PSS_ADDR_ACTIVE, 32'h0000_0011 * 32'(i + 1));
         wr(PSS_ADDR_REPEAT, 32'(i + 1));
         wr(PSS_ADDR_CMD, 32'h0000_0001);
      end
      wr(PSS_ADDR_ACTIVE, 32'h0000_0033);
      wr(PSS_ADDR_CTRL, 32'h0000_0001);
      foreach (auto_set[k]) begin
         if (k > 0)
            far.fire();
         see(auto_set[k]);
      end
      far.busy(1'b1);
      wr(PSS_ADDR_CTRL, 32'h0000_0000);
      chk(32'(sequencer_running), 32'h0000_0001);
      chk(active_params, 32'h0000_0011);
      far.busy(1'b0);
      repeat (4) @(posedge clock);
      chk(32'(sequencer_running), 32'h0000_0000);
      chk(active_params, 32'h0000_0033);
      wr(PSS_ADDR_CTRL, 32'h0000_0003);
      far.fire();
      see(1);
      wr(PSS_ADDR_CTRL, 32'h0000_0000);
      wr(PSS_ADDR_CTRL, 32'h0000_000B);
      far.lines(1'b1, 1'b0);
      far.fire();
      see(0);
      far.lines(1'b0, 1'b1);
      far.fire();
      see(1);
      wr(PSS_ADDR_CTRL, 32'h0000_0000);
      wr(PSS_ADDR_CTRL, 32'h0000_000F);
      far.fire();
      see(0);
      wr(PSS_ADDR_CMD, 32'h0000_0002);
      see(1);
      chk(32'(expo_cnt), 32'h0000_0008);
      test_done();
   end
endmodule : test_parameter_set_sequencer
